// ==== logic/rsse_core.sv ====
// execution of rotate-right, load-all-ones and sleep with an AHB-Lite slave
// Operation
// [RULE1] rotate right, lsb to msb, sets N,Z
// [RULE2] dest bit 0 to W, 1 to file
// [RULE3] access bit 0 access bank, 1 bank select
// [RULE4] a=0, extension on, f<=5Fh: indexed offset
// [RULE5] load-all-ones writes FFh, flags unchanged
// [RULE6] load-all-ones: a=0 access bank, 1 bank
// [RULE7] sleep clears power-down flag
// [RULE8] sleep sets timeout flag
// [RULE9] sleep clears watchdog and its postscaler
// [RULE10] sleep halts with oscillator stopped
// [RULE11] watchdog wake clears timeout flag
// [RULE12] one word, one four-phase instruction cycle
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
module rsse_core
  import rsse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] file_rdata,
  output rsse_file_t file_req,
  input wire logic wake_watchdog,
  input wire logic wake_other,
  output logic watchdog_clear,
  output logic osc_stop
);
  logic rst_m;
  logic rst_s;
  logic tick;
  rsse_state_t state;
  rsse_status_t status;
  logic [15:0] instr;
  logic ext_en;
  logic [3:0] bank_select_register;
  logic [11:0] index_base;
  logic [7:0] wreg;
  logic [7:0] operand;
  logic [7:0] result;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] next_rdata;
  logic start;
  rsse_dec_t dec;

  function automatic rsse_dec_t decode(input logic [15:0] w);
    rsse_dec_t d;
    d.rotate = (w[15:10] == ROT_OPC);
    d.set_ones = (w[15:9] == SET_OPC);
    d.sleep = (w == SLEEP_WORD);
    d.dest = w[DEST_BIT] & ~d.set_ones;
    d.acc = w[ACC_BIT];
    d.f = w[7:0];
    return d;
  endfunction

  function automatic logic [11:0] eff_addr(input rsse_dec_t d,
    input logic ext, input logic [3:0] bank, input logic [11:0] base);
    logic [11:0] a;
    if (d.acc)
      a = {bank, d.f}; // [RULE3] [RULE6]
    else if (ext && d.f <= IDX_LIMIT)
      a = base + {4'h0, d.f}; // [RULE4]
    else if (d.f <= IDX_LIMIT)
      a = {LOW_BANK, d.f}; // [RULE3] [RULE6]
    else
      a = {HIGH_BANK, d.f};
    return a;
  endfunction

  assign dec = decode(instr);

  // reset release through two flops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m <= 1'h0;
      rst_s <= 1'h0;
    end
    else
    begin
      rst_m <= 1'h1;
      rst_s <= rst_m;
    end
  end

  rsse_qdiv u_qdiv (
    .mclk(mclk),
    .rst_n(rst_s),
    .run(state != ST_IDLE && state != ST_SLEEP),
    .tick(tick)
  );

  // bus address phase is captured; writes land in the data phase
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      wr_pend <= 1'h0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'h0;
      hresp <= 1'h0;
    end
    else
    begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite)
        hrdata <= next_rdata;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      unique case (haddr[7:0])
        OFS_INSTR: next_rdata = {16'h0000, instr};
        OFS_CTRL: next_rdata = {31'h0, ext_en};
        OFS_BANK: next_rdata = {28'h0, bank_select_register};
        OFS_INDEX: next_rdata = {20'h0, index_base};
        OFS_WREG: next_rdata = {24'h0, wreg};
        OFS_STATUS: next_rdata = {25'h0, status};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // an instruction write is ignored while one is running or asleep
  assign start = wr_pend && wr_addr == OFS_INSTR && state == ST_IDLE;

  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      instr <= INSTR_RESET;
      ext_en <= CTRL_EXT_RESET;
      bank_select_register <= BANK_RESET;
      index_base <= INDEX_RESET;
    end
    else if (wr_pend)
    begin
      if (start)
        instr <= hwdata[15:0];
      if (wr_addr == OFS_CTRL)
        ext_en <= hwdata[CTRL_EXT_BIT];
      if (wr_addr == OFS_BANK)
        bank_select_register <= hwdata[3:0];
      if (wr_addr == OFS_INDEX)
        index_base <= hwdata[11:0];
    end
  end

  // one phase per tick: decode, read, process, write; then idle, or sleep until a wake
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE:
          if (start)
            state <= ST_DECODE;
        ST_DECODE:
          if (tick)
            state <= ST_READ; // [RULE12]
        ST_READ:
          if (tick)
            state <= ST_PROC; // [RULE12]
        ST_PROC:
          if (tick)
            state <= ST_WRITE; // [RULE12]
        ST_WRITE:
          if (tick)
            state <= dec.sleep ? ST_SLEEP : ST_IDLE; // [RULE10]
        ST_SLEEP:
          if (wake_watchdog || wake_other)
            state <= ST_IDLE;
      endcase
    end
  end

  // operand fetch and the rotate itself
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      operand <= 8'h00;
      result <= 8'h00;
    end
    else if (tick && state == ST_READ)
      operand <= file_rdata;
    else if (tick && state == ST_PROC)
      result <= dec.set_ones ? ALL_ONES
        : {operand[0], operand[7:1]}; // [RULE1] [RULE5]
  end

  // file port: read request issued as the read phase begins, write as the last phase ends
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
      file_req <= '0;
    else
    begin
      file_req.re <= 1'h0;
      file_req.we <= 1'h0;
      if (tick && state == ST_DECODE && (dec.rotate || dec.set_ones))
      begin
        file_req.re <= 1'h1;
        file_req.addr <= eff_addr(dec, ext_en,
          bank_select_register, index_base);
      end
      if (tick && state == ST_WRITE && (dec.set_ones ||
          (dec.rotate && dec.dest))) // [RULE2]
      begin
        file_req.we <= 1'h1;
        file_req.wdata <= result;
        file_req.addr <= eff_addr(dec, ext_en,
          bank_select_register, index_base);
      end
    end
  end

  // working register: software load, or rotate with dest bit clear
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
      wreg <= WREG_RESET;
    else if (tick && state == ST_WRITE && dec.rotate && !dec.dest)
      wreg <= result; // [RULE2]
    else if (wr_pend && wr_addr == OFS_WREG)
      wreg <= hwdata[7:0];
  end

  // status: flags only move on rotate; sleep and wake flags
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
      status <= STATUS_RESET;
    else
    begin
      status.busy <= (state != ST_IDLE && state != ST_SLEEP) || start;
      status.sleeping <= (state == ST_SLEEP) && !wake_other
        && !wake_watchdog;
      if (start)
        status.illegal <= 1'h0;
      if (tick && state == ST_WRITE)
      begin
        status.illegal <= !(dec.rotate || dec.set_ones || dec.sleep);
        if (dec.rotate)
        begin
          status.neg <= result[7]; // [RULE1]
          status.zero <= (result == 8'h00); // [RULE1]
        end
        if (dec.sleep)
        begin
          status.power_down_flag <= 1'h0; // [RULE7]
          status.timeout_flag <= 1'h1; // [RULE8]
        end
      end
      if (state == ST_SLEEP && wake_watchdog)
        status.timeout_flag <= 1'h0; // [RULE11]
    end
  end

  // the watchdog clear is a single pulse; the clock gate is a level
  always_ff @(posedge mclk or negedge rst_s)
  begin
    if (!rst_s)
    begin
      watchdog_clear <= 1'h0;
      osc_stop <= 1'h0;
    end
    else
    begin
      watchdog_clear <= tick && state == ST_WRITE && dec.sleep; // [RULE9]
      if (tick && state == ST_WRITE && dec.sleep)
        osc_stop <= 1'h1; // [RULE10]
      else if (state == ST_SLEEP && (wake_watchdog || wake_other))
        osc_stop <= 1'h0;
    end
  end

  a_rotate_wdata: assert property (@(posedge mclk) // [RULE1]
    disable iff (!rst_s) (tick && state == ST_WRITE && dec.rotate && dec.dest)
    |=> file_req.we && file_req.wdata == {$past(operand[0], 2),
    $past(operand[7:1], 2)})
    else $error("rotate result wrong");

  a_rotate_to_w: assert property (@(posedge mclk) // [RULE2]
    disable iff (!rst_s) (tick && state == ST_WRITE && dec.rotate && !dec.dest)
    |=> !file_req.we && wreg == $past(result))
    else $error("rotate to W misrouted");

  a_rotate_flags: assert property (@(posedge mclk) // [RULE1]
    disable iff (!rst_s) (tick && state == ST_WRITE && dec.rotate)
    |=> status.neg == $past(result[7])
    && status.zero == ($past(result) == 8'h00))
    else $error("rotate flags wrong");

  a_bank_addr: assert property (@(posedge mclk) // [RULE3] [RULE6]
    disable iff (!rst_s) (tick && state == ST_DECODE && dec.acc
    && (dec.rotate || dec.set_ones))
    |=> file_req.addr == {$past(bank_select_register), $past(dec.f)})
    else $error("bank addressing wrong");

  a_indexed_addr: assert property (@(posedge mclk) // [RULE4]
    disable iff (!rst_s) (tick && state == ST_DECODE && !dec.acc && ext_en
    && dec.f <= IDX_LIMIT && (dec.rotate || dec.set_ones))
    |=> file_req.addr == $past(index_base) + {4'h0, $past(dec.f)})
    else $error("indexed addressing wrong");

  a_load_all_ones_op_value: assert property (@(posedge mclk) // [RULE5]
    disable iff (!rst_s) (tick && state == ST_WRITE && dec.set_ones)
    |=> file_req.we && file_req.wdata == ALL_ONES
    && status.neg == $past(status.neg)
    && status.zero == $past(status.zero))
    else $error("load-all-ones wrong");

  a_access_low: assert property (@(posedge mclk) // [RULE6]
    disable iff (!rst_s)
    (tick && state == ST_DECODE && dec.set_ones && !dec.acc && !ext_en)
    |=> file_req.addr[11:8] == ($past(dec.f) <= IDX_LIMIT
    ? LOW_BANK : HIGH_BANK))
    else $error("access bank wrong");

  a_sleep_flags: assert property (@(posedge mclk) // [RULE7] [RULE8]
    disable iff (!rst_s) (tick && state == ST_WRITE && dec.sleep)
    |=> !status.power_down_flag && status.timeout_flag)
    else $error("sleep status flags wrong");

  a_sleep_wdt: assert property (@(posedge mclk) // [RULE9]
    disable iff (!rst_s)
    $rose(osc_stop) |-> watchdog_clear ##1 !watchdog_clear)
    else $error("watchdog not cleared once");

  a_sleep_halt: assert property (@(posedge mclk) // [RULE10]
    disable iff (!rst_s) (state == ST_SLEEP && !wake_watchdog && !wake_other)
    |=> osc_stop && !tick && !file_req.we)
    else $error("not halted in sleep");

  a_wake_to: assert property (@(posedge mclk) // [RULE11]
    disable iff (!rst_s) (state == ST_SLEEP && wake_watchdog)
    |=> !status.timeout_flag && !osc_stop)
    else $error("watchdog wake kept timeout");

  a_cycle_len: assert property (@(posedge mclk) // [RULE12]
    disable iff (!rst_s) start |=> state == ST_DECODE ##2 state == ST_READ
    ##2 state == ST_PROC ##2 state == ST_WRITE
    ##2 (state == ST_IDLE || state == ST_SLEEP))
    else $error("instruction cycle length wrong");
endmodule

// ==== logic/rsse_qdiv.sv ====
// divider that makes the one-cycle phase enable of the instruction clock
`timescale 1ns/1ps
module rsse_qdiv
  import rsse_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [1:0] div;

  // phases stop when the oscillator is stopped or the core is idle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div <= 2'h0;
      tick <= 1'h0;
    end
    // preloaded so the first phase after a start is as long as the rest
    else if (!run)
    begin
      div <= Q_DIV_LAST;
      tick <= 1'h0;
    end
    else if (div == Q_DIV_LAST)
    begin
      div <= 2'h0;
      tick <= 1'h1;
    end
    else
    begin
      div <= div + 2'h1;
      tick <= 1'h0;
    end
  end
endmodule

// ==== pkg/rsse_pkg.sv ====
// constants and carrier types for the rotate/set/sleep execution block
package rsse_pkg;
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_INDEX = 8'h0C;
  localparam logic [7:0] OFS_WREG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic CTRL_EXT_RESET = 1'h0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] INDEX_RESET = 12'h000;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  localparam logic [5:0] ROT_OPC = 6'h10;
  localparam logic [6:0] SET_OPC = 7'h34;
  localparam logic [15:0] SLEEP_WORD = 16'h0003;
  localparam int DEST_BIT = 9;
  localparam int ACC_BIT = 8;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [3:0] LOW_BANK = 4'h0;
  localparam logic [3:0] HIGH_BANK = 4'hF;
  localparam int MCLK_NS = 25;
  localparam int Q_PHASE_NS = 50;
  localparam int Q_DIV = Q_PHASE_NS / MCLK_NS;
  localparam logic [1:0] Q_DIV_LAST = 2'(Q_DIV - 1);
  localparam int INSTR_PHASES = 4;
  localparam int INSTR_CLKS = INSTR_PHASES * Q_DIV;

  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_READ, ST_PROC, ST_WRITE, ST_SLEEP
  } rsse_state_t;

  typedef struct packed {
    logic sleeping;
    logic busy;
    logic illegal;
    logic timeout_flag;
    logic power_down_flag;
    logic neg;
    logic zero;
  } rsse_status_t;

  localparam rsse_status_t STATUS_RESET = 7'h0C;

  typedef struct packed {
    logic re;
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } rsse_file_t;

  typedef struct packed {
    logic rotate;
    logic set_ones;
    logic sleep;
    logic dest;
    logic acc;
    logic [7:0] f;
  } rsse_dec_t;
endpackage

// ==== tb/testbench.sv ====
// self-checking bench for the rotate/load-all-ones/sleep execution block
`timescale 1ns/1ps
module testbench;
  import rsse_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] file_rdata;
  rsse_file_t file_req;
  logic wake_watchdog = 1'b0;
  logic wake_other = 1'b0;
  logic watchdog_clear;
  logic osc_stop;
  logic [7:0] fmem [0:4095];
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int e0 = 0;
  int we_cyc = 0;
  int we_n = 0;
  int wdc_n = 0;
  int re_n = 0;
  logic [11:0] we_a = 12'h000;
  logic [7:0] we_d = 8'h00;

  always #12.5 mclk = ~mclk;
  // the register file answers combinationally for whatever address is out
  assign file_rdata = fmem[file_req.addr];

  rsse_core i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .file_rdata(file_rdata), .file_req(file_req),
    .wake_watchdog(wake_watchdog), .wake_other(wake_other),
    .watchdog_clear(watchdog_clear), .osc_stop(osc_stop));

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (file_req.we === 1'b1)
    begin
      we_n <= we_n + 1;
      we_a <= file_req.addr;
      we_d <= file_req.wdata;
      we_cyc <= cyc;
    end
    if (watchdog_clear === 1'b1)
      wdc_n <= wdc_n + 1;
    if (file_req.re === 1'b1)
      re_n <= re_n + 1;
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic ahb_xfer(input logic wr, input logic [7:0] ofs,
                          input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge mclk iff hreadyout === 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge mclk iff hreadyout === 1'b1);
    rd = hrdata;
  endtask

  task automatic ahb_wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] dummy;
    ahb_xfer(1'b1, ofs, wd, dummy);
  endtask

  task automatic ahb_rd(input logic [7:0] ofs, output logic [31:0] rd);
    ahb_xfer(1'b0, ofs, 32'h00000000, rd);
  endtask

  task automatic run_op(input logic [15:0] w);
    logic [31:0] s;
    int i;
    ahb_wr(OFS_INSTR, {16'h0000, w});
    e0 = cyc;
    s = 32'h00000020;
    i = 0;
    while (s[5] !== 1'b0 && i < 20)
    begin
      ahb_rd(OFS_STATUS, s);
      i++;
    end
    check("busy clears", 32'h0, {31'h0, s[5]});
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ofs,
                        input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    ahb_rd(ofs, v);
    check(what, exp, v & mask);
    check("hresp okay", 32'h0, {31'h0, hresp});
  endtask

  task automatic t_reset;
    rd_chk("status reset", OFS_STATUS, 32'hFFFFFFFF, 32'h0000000C);
    rd_chk("wreg reset", OFS_WREG, 32'hFFFFFFFF, 32'h00000000);
    rd_chk("unmapped", 8'h18, 32'hFFFFFFFF, 32'h00000000);
    check("osc reset", 32'h0, {31'h0, osc_stop});
    $display("test reset done");
  endtask

  task automatic t_rot_file;
    int r;
    r = re_n;
    fmem[12'h325] = 8'hD7;
    ahb_wr(OFS_BANK, 32'h00000003);
    run_op(16'h4325);
    check("we addr bank", 32'h325, {20'h0, we_a});
    check("rotate data", 32'hEB, {24'h0, we_d});
    check("we timing", 32'(INSTR_CLKS + 1), 32'(we_cyc - e0));
    check("one read", 32'(r + 1), 32'(re_n));
    rd_chk("flags neg", OFS_STATUS, 32'h7F, 32'h0E);
    $display("test rotate to file done");
  endtask

  task automatic t_rot_w;
    int n;
    n = we_n;
    fmem[12'hF90] = 8'h00;
    fmem[12'h010] = 8'h01;
    // preload so that a missing zero write shows
    ahb_wr(OFS_WREG, 32'h0000005A);
    run_op(16'h4090);
    rd_chk("wreg zero", OFS_WREG, 32'hFF, 32'h00);
    rd_chk("flags zero", OFS_STATUS, 32'h7F, 32'h0D);
    run_op(16'h4010);
    rd_chk("wreg rot", OFS_WREG, 32'hFF, 32'h80);
    check("no file write", 32'(n), 32'(we_n));
    $display("test rotate to wreg done");
  endtask

  task automatic t_indexed;
    // result 01h leaves N and Z clear, unlike what FFh would give
    fmem[12'h25F] = 8'h02;
    ahb_wr(OFS_CTRL, 32'h00000001);
    ahb_wr(OFS_INDEX, 32'h00000200);
    run_op(16'h425F);
    check("indexed addr", 32'h25F, {20'h0, we_a});
    check("indexed data", 32'h01, {24'h0, we_d});
    run_op(16'h6860);
    check("above limit", 32'hF60, {20'h0, we_a});
    check("ones data", 32'hFF, {24'h0, we_d});
    rd_chk("flags kept", OFS_STATUS, 32'h7F, 32'h0C);
    ahb_wr(OFS_CTRL, 32'h00000000);
    $display("test indexed done");
  endtask

  task automatic t_set_bank;
    ahb_wr(OFS_BANK, 32'h00000005);
    run_op(16'h6912);
    check("ones bank", 32'h512, {20'h0, we_a});
    run_op(16'h6812);
    check("ones access", 32'h012, {20'h0, we_a});
    check("ones data", 32'hFF, {24'h0, we_d});
    $display("test load ones done");
  endtask

  task automatic t_busy;
    int n;
    n = we_n;
    run_op(16'h1234);
    rd_chk("illegal", OFS_STATUS, 32'h10, 32'h10);
    check("illegal no write", 32'(n), 32'(we_n));
    fmem[12'h525] = 8'h00;
    ahb_wr(OFS_INSTR, 32'h00004325);
    // second word lands while busy and must be dropped
    run_op(16'h6930);
    check("one write", 32'(n + 1), 32'(we_n));
    check("first kept", 32'h525, {20'h0, we_a});
    $display("test busy done");
  endtask

  task automatic t_sleep;
    int n;
    int w;
    n = we_n;
    w = wdc_n;
    run_op(SLEEP_WORD);
    repeat (2) @(posedge mclk);
    check("wdt cleared", 32'(w + 1), 32'(wdc_n));
    check("osc stopped", 32'h1, {31'h0, osc_stop});
    rd_chk("sleep flags", OFS_STATUS, 32'h4C, 32'h48);
    ahb_wr(OFS_INSTR, 32'h00004325);
    repeat (12) @(posedge mclk);
    check("halted", 32'(n), 32'(we_n));
    wake_watchdog <= 1'b1;
    @(posedge mclk);
    wake_watchdog <= 1'b0;
    repeat (3) @(posedge mclk);
    check("osc woke", 32'h0, {31'h0, osc_stop});
    rd_chk("wdt wake", OFS_STATUS, 32'h4C, 32'h00);
    run_op(SLEEP_WORD);
    rd_chk("sleep again", OFS_STATUS, 32'h4C, 32'h48);
    wake_other <= 1'b1;
    @(posedge mclk);
    wake_other <= 1'b0;
    repeat (3) @(posedge mclk);
    rd_chk("other wake", OFS_STATUS, 32'h4C, 32'h08);
    $display("test sleep done");
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // a whole run needs a few hundred cycles; this leaves wide margin
  initial
  begin
    #(25 * 20000);
    err_total++;
    test_done();
  end

  initial
  begin
    for (int i = 0; i < 4096; i++)
      fmem[i] = 8'h00;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_reset();
    t_rot_file();
    t_rot_w();
    t_indexed();
    t_set_bank();
    t_busy();
    t_sleep();
    test_done();
  end
endmodule
